// >>> design/clk_nmi_map.svh
// source indices, field codes, reset values and timing counts of the clock select and nmi block
`ifndef CLK_NMI_MAP_SVH
`define CLK_NMI_MAP_SVH

// ----------------------------------------------------------------
// oscillator select codes
// ----------------------------------------------------------------
`define OSC_CODE_MAIN      3'h0
`define OSC_CODE_INT       3'h1
`define OSC_CODE_INT_DIV4  3'h2
`define OSC_CODE_LOWFREQ   3'h3
`define OSC_CODE_RTC       3'h7

// ----------------------------------------------------------------
// source indices into the switch
// ----------------------------------------------------------------
`define SRC_IDX_MAIN       3'h0
`define SRC_IDX_INT        3'h1
`define SRC_IDX_INT_DIV4   3'h2
`define SRC_IDX_LOWFREQ    3'h3
`define SRC_IDX_RTC        3'h4
`define SRC_IDX_PLL        3'h5
`define SRC_IDX_RESET      `SRC_IDX_INT

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define REG_ADJUST_RESET   6'h00
`define CLK_PERIOD_NS      20
`define OSC_CHECK_NS       1000
`define OSC_CHECK_CYCLES   (`OSC_CHECK_NS / `CLK_PERIOD_NS)

`endif

// >>> design/clk_nmi_pkg.sv
// types of the clock select and nmi block
package clk_nmi_pkg;

    typedef logic [2:0] srcIdx_t;

    typedef struct packed {
        logic       bypass;
        logic [1:0] oscSelect;
        logic       useDivisor;
        logic [3:0] divisorField;
    } clockConfig_s;

    typedef struct packed {
        logic       useExtConfig;
        logic       bypass;
        logic [2:0] oscSelectExt;
        logic [5:0] divisorField;
    } clockConfigExt_s;

    typedef enum logic [1:0] {
        SW_RUN   = 2'b00,
        SW_DRAIN = 2'b01,
        SW_HOLD  = 2'b11
    } switch_e;

endpackage : clk_nmi_pkg

// >>> design/clk_switch.sv
// glitch-free selector between sampled clock source levels
`timescale 1ns/1ps
`include "clk_nmi_map.svh"

module clk_switch
    import clk_nmi_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] srcLevel,
    input  wire srcIdx_t    reqIdx,
    output srcIdx_t         activeIdx_ff,
    output logic            clkOut_ff
);

    switch_e state_ff;
    switch_e nxt_state;
    srcIdx_t nxt_activeIdx;
    logic    nxt_clkOut;

    wire logic oldLevel = srcLevel[activeIdx_ff];
    wire logic newLevel = srcLevel[reqIdx];

    // ----------------------------------------------------------------
    // switch sequence
    // ----------------------------------------------------------------
    // output is only gated off while the old source is low and only
    // reopened while the new one is low, so no pulse is ever cut short
    always_comb begin
        nxt_state     = state_ff;
        nxt_activeIdx = activeIdx_ff;
        nxt_clkOut    = 1'b0;
        case (state_ff)
            SW_RUN: begin
                nxt_clkOut = oldLevel;
                if (reqIdx != activeIdx_ff) begin
                    nxt_state = SW_DRAIN;
                end
            end
            SW_DRAIN: begin
                nxt_clkOut = oldLevel;
                if (!oldLevel) begin
                    nxt_clkOut = 1'b0;
                    nxt_state  = SW_HOLD;
                end
            end
            SW_HOLD: begin
                if (!newLevel) begin
                    nxt_activeIdx = reqIdx;
                    nxt_state     = SW_RUN;
                end
            end
            default: begin
                nxt_state = SW_RUN;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_ff     <= SW_RUN;
            activeIdx_ff <= `SRC_IDX_RESET;
            clkOut_ff    <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            activeIdx_ff <= nxt_activeIdx;
            clkOut_ff    <= nxt_clkOut;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_gap_low;
        @(posedge mclk) disable iff (sys_rst)
        (state_ff == SW_HOLD) |=> !clkOut_ff || (activeIdx_ff != $past(activeIdx_ff));
    endproperty
    a_gap_low: assert property (p_gap_low) else $error("output high while switching");

    property p_drain_old_low;
        @(posedge mclk) disable iff (sys_rst)
        (state_ff == SW_DRAIN) ##1 (state_ff == SW_HOLD) |-> !$past(oldLevel);
    endproperty
    a_drain_old_low: assert property (p_drain_old_low) else $error("old source cut high");

    c_switch_done: cover property (@(posedge mclk) disable iff (sys_rst)
        (state_ff == SW_HOLD) ##1 (state_ff == SW_RUN));

endmodule : clk_switch

// >>> design/clock_source_select_nmi.sv
// system clock source selection, divisor, nmi merge, oscillator check and regulator adjust
`timescale 1ns/1ps
`include "clk_nmi_map.svh"

module clock_source_select_nmi
    import clk_nmi_pkg::*;
(
    input  wire logic            mclk,
    input  wire logic            sys_rst,
    input  wire logic            mainOsc,
    input  wire logic            intOsc,
    input  wire logic            lowFreqOsc,
    input  wire logic            rtcOsc,
    input  wire logic            pllOut,
    input  wire clockConfig_s    clockConfigReg,
    input  wire clockConfigExt_s clockConfigExtReg,
    input  wire logic            oscCheckEnable,
    input  wire logic            nmiPin,
    input  wire logic            altFuncEnable,
    input  wire logic            portUnlocked,
    input  wire logic            portCommit,
    input  wire logic            nmiAck,
    input  wire logic            resetCauseClear,
    input  wire logic            adjustWrite,
    input  wire logic [5:0]      adjustValue,
    output logic                 systemClock_ff,
    output logic                 pllRefEnable_ff,
    output logic                 nmi_ff,
    output logic                 porRequest_ff,
    output logic                 mainOscFailFlag_ff,
    output logic                 nmiPinEnabled_ff,
    output logic [5:0]           regulatorVoltageAdjust_ff
);

    // ----------------------------------------------------------------
    // selection decode
    // ----------------------------------------------------------------
    // codes without a source fall back to the internal oscillator
    function automatic srcIdx_t decodeSource(input logic bypass, input logic [2:0] code);
        srcIdx_t idx;
        idx = `SRC_IDX_INT;
        if (!bypass && code == `OSC_CODE_MAIN) begin
            idx = `SRC_IDX_PLL;
        end else begin
            case (code)
                `OSC_CODE_MAIN:     idx = `SRC_IDX_MAIN;
                `OSC_CODE_INT:      idx = `SRC_IDX_INT;
                `OSC_CODE_INT_DIV4: idx = `SRC_IDX_INT_DIV4;
                `OSC_CODE_LOWFREQ:  idx = `SRC_IDX_LOWFREQ;
                `OSC_CODE_RTC:      idx = `SRC_IDX_RTC;
                default:            idx = `SRC_IDX_INT;
            endcase
        end
        return idx;
    endfunction : decodeSource

    wire logic       useExt    = clockConfigExtReg.useExtConfig;
    wire logic       effBypass = useExt ? clockConfigExtReg.bypass
                                        : clockConfigReg.bypass;
    wire logic [2:0] effCode   = useExt ? clockConfigExtReg.oscSelectExt
                                        : {1'b0, clockConfigReg.oscSelect};
    wire logic [5:0] divM1     = useExt ? clockConfigExtReg.divisorField
                               : (clockConfigReg.useDivisor ? {2'b00, clockConfigReg.divisorField}
                                                            : 6'h00);
    wire srcIdx_t    selIdx    = decodeSource(effBypass, effCode);
    wire logic       pllRefOn  = !effBypass && (effCode == `OSC_CODE_MAIN);

    // ----------------------------------------------------------------
    // internal oscillator divided by four
    // ----------------------------------------------------------------
    logic intPrev_ff;
    logic intHalf_ff;
    logic intDiv4_ff;
    wire logic intRise = intOsc && !intPrev_ff;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            intPrev_ff <= 1'b0;
            intHalf_ff <= 1'b0;
            intDiv4_ff <= 1'b0;
        end else begin
            intPrev_ff <= intOsc;
            if (intRise) begin
                intHalf_ff <= !intHalf_ff;
                if (intHalf_ff) begin
                    intDiv4_ff <= !intDiv4_ff;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // glitch-free source switch
    // ----------------------------------------------------------------
    wire logic [7:0] srcLevel = {2'b00, pllOut, rtcOsc, lowFreqOsc,
                                 intDiv4_ff, intOsc, mainOsc};
    srcIdx_t   activeIdx;
    logic      switchedClk;

    clk_switch u_switch (
        .mclk         (mclk),
        .sys_rst      (sys_rst),
        .srcLevel     (srcLevel),
        .reqIdx       (selIdx),
        .activeIdx_ff (activeIdx),
        .clkOut_ff    (switchedClk)
    );

    // ----------------------------------------------------------------
    // system clock divisor
    // ----------------------------------------------------------------
    // counts rising edges of the switched source; a divisor change
    // takes effect at the next rising edge (at once for a divisor of one), not at a wrap
    logic       swPrev_ff;
    logic [5:0] divCnt_ff;
    wire logic       swRise   = switchedClk && !swPrev_ff;
    wire logic       divWrap  = (divCnt_ff >= divM1);
    wire logic [5:0] nxt_cnt  = divWrap ? 6'h00 : divCnt_ff + 6'h01;
    wire logic [6:0] divisor  = {1'b0, divM1} + 7'h01;
    wire logic [5:0] halfDiv  = divisor[6:1];
    wire logic       nxt_systemClock = (divM1 == 6'h00) ? switchedClk
                                 : (swRise ? (nxt_cnt < halfDiv) : systemClock_ff);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            swPrev_ff      <= 1'b0;
            divCnt_ff      <= 6'h00;
            systemClock_ff <= 1'b0;
            pllRefEnable_ff <= 1'b0;
        end else begin
            swPrev_ff      <= switchedClk;
            if (swRise) begin
                divCnt_ff <= nxt_cnt;
            end
            systemClock_ff <= nxt_systemClock;
            pllRefEnable_ff <= pllRefOn;
        end
    end

    // ----------------------------------------------------------------
    // main oscillator check
    // ----------------------------------------------------------------
    // a missing edge for the whole window counts as failure; the
    // failure is reported once until the check is turned off
    logic       mainPrev_ff;
    logic [5:0] stallCnt_ff;
    logic       failLatched_ff;
    logic       failNmiPending_ff;
    wire logic mainEdge  = mainOsc != mainPrev_ff;
    wire logic stallEnd  = stallCnt_ff == 6'(`OSC_CHECK_CYCLES - 1);
    wire logic failEvent = oscCheckEnable && !mainEdge && stallEnd && !failLatched_ff;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mainPrev_ff    <= 1'b0;
            stallCnt_ff    <= 6'h00;
            failLatched_ff <= 1'b0;
        end else begin
            mainPrev_ff <= mainOsc;
            if (!oscCheckEnable || mainEdge) begin
                stallCnt_ff <= 6'h00;
            end else if (!stallEnd) begin
                stallCnt_ff <= stallCnt_ff + 6'h01;
            end
            failLatched_ff <= oscCheckEnable && (failLatched_ff || failEvent);
        end
    end

    // ----------------------------------------------------------------
    // reset cause flag, reset request and nmi merge
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mainOscFailFlag_ff <= 1'b0;
            porRequest_ff      <= 1'b0;
            failNmiPending_ff  <= 1'b0;
            nmiPinEnabled_ff   <= 1'b0;
            nmi_ff             <= 1'b0;
        end else begin
            // set beats a clear in the same cycle
            mainOscFailFlag_ff <= failEvent || (mainOscFailFlag_ff && !resetCauseClear);
            porRequest_ff      <= failEvent;
            failNmiPending_ff  <= failEvent || (failNmiPending_ff && !nmiAck);
            if (portUnlocked && portCommit) begin
                nmiPinEnabled_ff <= altFuncEnable;
            end
            nmi_ff <= (nmiPinEnabled_ff && nmiPin) || failNmiPending_ff;
        end
    end

    // ----------------------------------------------------------------
    // regulator adjust
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            regulatorVoltageAdjust_ff <= `REG_ADJUST_RESET;
        end else if (adjustWrite) begin
            regulatorVoltageAdjust_ff <= adjustValue;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_pin_nmi;
        (nmiPinEnabled_ff && nmiPin) |=> nmi_ff;
    endproperty
    a_pin_nmi: assert property (p_pin_nmi) else $error("pin did not raise nmi");

    property p_no_source;
        (!nmiPinEnabled_ff && !failNmiPending_ff) |=> !nmi_ff;
    endproperty
    a_no_source: assert property (p_no_source) else $error("nmi without source");

    property p_locked;
        !(portUnlocked && portCommit) |=> $stable(nmiPinEnabled_ff);
    endproperty
    a_locked: assert property (p_locked) else $error("pin enable changed while locked");

    property p_fail_seq;
        failEvent |=> (porRequest_ff && mainOscFailFlag_ff) ##1 !porRequest_ff ##1 nmi_ff;
    endproperty
    a_fail_seq: assert property (p_fail_seq) else $error("fail sequence broken");

    property p_check_off;
        !oscCheckEnable |=> !porRequest_ff;
    endproperty
    a_check_off: assert property (p_check_off) else $error("reset with check off");

    property p_flag_sticky;
        (mainOscFailFlag_ff && !resetCauseClear) |=> mainOscFailFlag_ff;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("fail flag lost");

    property p_adjust;
        adjustWrite |=> regulatorVoltageAdjust_ff == $past(adjustValue);
    endproperty
    a_adjust: assert property (p_adjust) else $error("regulator field not taken");

    property p_reset_src;
        @(posedge mclk) disable iff (1'b0)
        sys_rst |=> activeIdx == `SRC_IDX_INT;
    endproperty
    a_reset_src: assert property (p_reset_src) else $error("not internal after reset");

    property p_override;
        (useExt && clockConfigExtReg.bypass
            && clockConfigExtReg.oscSelectExt == `OSC_CODE_RTC) |-> selIdx == `SRC_IDX_RTC;
    endproperty
    a_override: assert property (p_override) else $error("extended select ignored");

    c_pin_nmi:   cover property (nmiPinEnabled_ff && nmiPin ##1 nmi_ff);
    c_fail:      cover property (failEvent ##1 porRequest_ff);
    c_divided:   cover property ((divM1 != 6'h00) && swRise && divWrap);

endmodule : clock_source_select_nmi

// >>> sim/src_clock_model.sv
// source oscillator model for the clock select and nmi block
`timescale 1ns/1ps

module src_clock_model (
    input  wire logic mclk,
    input  wire logic mainStop,
    output wire logic mainOsc,
    output wire logic intOsc,
    output wire logic lowFreqOsc,
    output wire logic rtcOsc,
    output wire logic pllOut
);
    // ----------------------------------------------------------------
    // half periods in mclk cycles
    // ----------------------------------------------------------------
    // distinct so that each source shows a period of its own at the output
    localparam int HALF_MAIN = 3;
    localparam int HALF_INT  = 4;
    localparam int HALF_LOW  = 7;
    localparam int HALF_RTC  = 9;
    localparam int HALF_PLL  = 5;

    int         cyc = 0;
    logic [4:0] lvl = 5'h00;

    assign {mainOsc, intOsc, lowFreqOsc, rtcOsc, pllOut} = lvl;

    always @(negedge mclk) begin
        cyc <= cyc + 1;
        // a failed crystal stands still at its last level
        if (!mainStop && cyc % HALF_MAIN == 0) lvl[4] <= ~lvl[4];
        if (cyc % HALF_INT == 0) lvl[3] <= ~lvl[3];
        if (cyc % HALF_LOW == 0) lvl[2] <= ~lvl[2];
        if (cyc % HALF_RTC == 0) lvl[1] <= ~lvl[1];
        if (cyc % HALF_PLL == 0) lvl[0] <= ~lvl[0];
    end
endmodule : src_clock_model

// >>> sim/tb.sv
// self-checking testbench of the clock select and nmi block
`timescale 1ns/1ps

module tb
    import clk_nmi_pkg::*;
;
    logic mclk = 1'h0, sys_rst = 1'h1, mainStop = 1'h0;
    logic mainOsc, intOsc, lowFreqOsc, rtcOsc, pllOut;
    clockConfig_s    cfg;
    clockConfigExt_s cfgExt;
    logic oscCheckEnable, nmiPin, altFuncEnable, portUnlocked, portCommit;
    logic nmiAck, resetCauseClear, adjustWrite;
    logic [5:0] adjustValue, regAdjust;
    logic divClk, pllRef, nmi, por, failFlag, pinEnabled;
    int   error_cnt = 0, samples_checked = 0, porCnt = 0, runLen = 0, edges = 0, per;
    logic lastClk = 1'h0, monEn = 1'h0;

    always #10 mclk = ~mclk;

    src_clock_model i_src (.mclk(mclk), .mainStop(mainStop), .mainOsc(mainOsc),
        .intOsc(intOsc), .lowFreqOsc(lowFreqOsc), .rtcOsc(rtcOsc), .pllOut(pllOut));

    clock_source_select_nmi i_dut (.mclk(mclk), .sys_rst(sys_rst), .mainOsc(mainOsc),
        .intOsc(intOsc), .lowFreqOsc(lowFreqOsc), .rtcOsc(rtcOsc), .pllOut(pllOut),
        .clockConfigReg(cfg), .clockConfigExtReg(cfgExt), .oscCheckEnable(oscCheckEnable),
        .nmiPin(nmiPin), .altFuncEnable(altFuncEnable), .portUnlocked(portUnlocked),
        .portCommit(portCommit), .nmiAck(nmiAck), .resetCauseClear(resetCauseClear),
        .adjustWrite(adjustWrite), .adjustValue(adjustValue), .systemClock_ff(divClk),
        .pllRefEnable_ff(pllRef), .nmi_ff(nmi), .porRequest_ff(por),
        .mainOscFailFlag_ff(failFlag), .nmiPinEnabled_ff(pinEnabled),
        .regulatorVoltageAdjust_ff(regAdjust));

    // ----------------------------------------------------------------
    // monitors
    // ----------------------------------------------------------------
    always @(posedge mclk) begin
        if (por === 1'h1) porCnt <= porCnt + 1;
        if (divClk !== lastClk) begin
            // the first level after time zero may be partial, so two edges since then enable it
            if (monEn && edges > 1 && runLen < 3) begin
                error_cnt <= error_cnt + 1;
                $display("unexpected runt on system clock: expected 3 seen %0d", runLen);
            end
            edges   <= edges + 1;
            runLen  <= 1;
            lastClk <= divClk;
        end else begin
            runLen <= runLen + 1;
        end
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(negedge mclk);
    endtask : step

    // rising edge to rising edge of the system clock, in mclk cycles
    task automatic measure(input int exp);
        int n;
        logic prev;
        step(150);
        prev = divClk;
        for (n = 0; n < 1000 && !(!prev && divClk === 1'h1); n++) begin
            prev = divClk;
            step(1);
        end
        per = 0;
        prev = 1'h1;
        while (per < 1000 && !(!prev && divClk === 1'h1)) begin
            prev = divClk;
            step(1);
            per++;
        end
        chk("system clock period", exp, per);
    endtask : measure

    task automatic set_cfg(input clockConfig_s c, input clockConfigExt_s e);
        step(1);
        cfg    = c;
        cfgExt = e;
    endtask : set_cfg

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        chk("outputs after reset", 6'h00, {nmi, por, failFlag, pinEnabled, pllRef});
        chk("voltage adjust", 6'h00, regAdjust);
        measure(8);
    endtask : t_reset

    task automatic t_select;
        clockConfig_s tbl [4];
        int           exp [4];
        tbl = '{'{1'h1, 2'h1, 1'h0, 4'h0}, '{1'h1, 2'h2, 1'h0, 4'h0},
                '{1'h1, 2'h0, 1'h0, 4'h0}, '{1'h1, 2'h3, 1'h0, 4'h0}};
        exp = '{8, 32, 6, 14};
        monEn = 1'h1;
        // main runs from time zero, long stable before it is chosen
        foreach (tbl[i]) begin
            set_cfg(tbl[i], '0);
            measure(exp[i]);
        end
        set_cfg(tbl[0], '{1'h1, 1'h1, 3'h7, 6'h00});
        measure(18);
        set_cfg(tbl[0], '{1'h1, 1'h1, 3'h5, 6'h00});
        measure(8);
        // bypass clear with a code other than main behaves as bypassed
        set_cfg('{1'h0, 2'h1, 1'h0, 4'h0}, '0);
        measure(8);
        set_cfg('{1'h0, 2'h0, 1'h0, 4'h0}, '0);
        step(2);
        chk("pll reference enable", 1'h1, pllRef);
        measure(10);
        set_cfg('{1'h0, 2'h0, 1'h0, 4'h0}, '{1'h1, 1'h1, 3'h0, 6'h00});
        measure(6);
        chk("pll reference enable", 1'h0, pllRef);
        monEn = 1'h0;
    endtask : t_select

    task automatic t_divisor;
        // divisor field is ignored while its use bit is clear
        set_cfg('{1'h1, 2'h0, 1'h0, 4'h3}, '0);
        measure(6);
        set_cfg('{1'h1, 2'h0, 1'h1, 4'h3}, '0);
        measure(24);
        set_cfg('{1'h1, 2'h0, 1'h1, 4'hF}, '0);
        measure(96);
        set_cfg('{1'h1, 2'h1, 1'h0, 4'h0}, '{1'h1, 1'h1, 3'h0, 6'h3F});
        measure(384);
        set_cfg('{1'h1, 2'h1, 1'h0, 4'h0}, '0);
    endtask : t_divisor

    task automatic t_nmi_pin;
        nmiPin        = 1'h1;
        altFuncEnable = 1'h1;
        portUnlocked  = 1'h1;
        step(3);
        chk("pin enabled without commit", 1'h0, pinEnabled);
        chk("nmi from locked pin", 1'h0, nmi);
        portCommit = 1'h1;
        step(1);
        chk("pin enabled", 1'h1, pinEnabled);
        step(1);
        chk("nmi from pin", 1'h1, nmi);
        nmiPin = 1'h0;
        step(2);
        chk("nmi after pin low", 1'h0, nmi);
        chk("fail flag on pin nmi", 1'h0, failFlag);
        altFuncEnable = 1'h0;
        step(2);
        nmiPin = 1'h1;
        step(3);
        chk("nmi from disabled pin", 1'h0, nmi);
        {nmiPin, portUnlocked, portCommit} = 3'h0;
    endtask : t_nmi_pin

    task automatic t_osc_fail;
        int n;
        oscCheckEnable = 1'h1;
        step(120);
        oscCheckEnable = 1'h0;
        mainStop       = 1'h1;
        step(120);
        chk("reset requests while unchecked", 0, porCnt);
        oscCheckEnable = 1'h1;
        for (n = 0; n < 120 && por !== 1'h1; n++) step(1);
        chk("fail flag with reset request", 1'h1, failFlag);
        step(1);
        chk("reset request width", 1'h0, por);
        chk("nmi after check failure", 1'h1, nmi);
        chk("fail flag tells nmi source", 1'h1, failFlag);
        nmiAck = 1'h1;
        step(1);
        nmiAck = 1'h0;
        step(3);
        chk("nmi after ack", 1'h0, nmi);
        chk("reset requests", 1, porCnt);
        chk("sticky fail flag", 1'h1, failFlag);
        resetCauseClear = 1'h1;
        oscCheckEnable  = 1'h0;
        step(1);
        resetCauseClear = 1'h0;
        mainStop        = 1'h0;
        step(1);
        chk("fail flag after clear", 1'h0, failFlag);
    endtask : t_osc_fail

    task automatic t_adjust;
        adjustValue = 6'h2A;
        adjustWrite = 1'h1;
        step(1);
        adjustWrite = 1'h0;
        adjustValue = 6'h15;
        chk("voltage adjust", 6'h2A, regAdjust);
        step(2);
        chk("voltage adjust held", 6'h2A, regAdjust);
        adjustValue = 6'h3F;
        adjustWrite = 1'h1;
        step(1);
        adjustWrite = 1'h0;
        chk("voltage adjust", 6'h3F, regAdjust);
    endtask : t_adjust

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (60000) @(posedge mclk);
        error_cnt++;
        $display("unexpected run length: expected end before 60000 cycles seen hang");
        tally_and_finish();
    end

    initial begin
        cfg    = '{1'h1, 2'h1, 1'h0, 4'h0};
        cfgExt = '0;
        {oscCheckEnable, nmiPin, altFuncEnable, portUnlocked, portCommit} = 5'h00;
        {nmiAck, resetCauseClear, adjustWrite} = 3'h0;
        adjustValue = 6'h00;
        step(2);
        sys_rst = 1'h0;
        step(1);
        t_reset();
        t_select();
        t_divisor();
        t_nmi_pin();
        t_osc_fail();
        t_adjust();
        tally_and_finish();
    end
endmodule : tb
